// file: logic/gfx_dev.sv
// display controller end: command decode, copy/clear engine, scroll state
// Notes on behaviour
// - host sends copy code plus six coordinates
// - copy duplicates source rectangle to destination
// - host sends clear code plus four coordinates
// - fill option bit 0 enables fill
// - bit 4 inverts copied gray levels
// - host sets scroll before activation, never during
// - activate scrolls with latest setup values
// - deactivate stops; host must rewrite RAM
// - vertical area takes exactly three bytes
// - frame is div times rows times K
// - soft reset aborts operation, pulses reset
// - clear writes zero inside the rectangle
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gfx_dev
  import gfx_pkg::*;
#(
  parameter int COLS = 160,
  parameter int ROWS = 132,
  parameter int PIXW = 18
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  gfx_link_if.dev                          lnk,
  input  wire logic [7:0]                  pix_col,
  input  wire logic [7:0]                  pix_row,
  output logic      [PIXW-1:0]             pix_data,
  input  wire logic [4:0]                  div_ratio,
  input  wire logic [5:0]                  ph1_clks,
  input  wire logic [3:0]                  ph2_clks,
  output logic      [31:0]                 frame_len,
  output logic                             frame_tick,
  output logic                             fill_en,
  output logic                             rev_copy,
  output logic                             scroll_active,
  output logic      [NPAR_SCR*8-1:0]       scroll_cfg,
  output logic      [NPAR_VSCR*8-1:0]      vscroll_area,
  output logic                             soft_rst
);
  localparam int AW = $clog2(COLS * ROWS);

  typedef struct packed {
    dev_state_t                 st;
    logic [7:0]                 op;
    logic [2:0]                 idx;
    logic [5:0][7:0]            par;
    logic                       fill;
    logic                       rev;
    logic [NPAR_SCR-1:0][7:0]   scr;
    logic                       scr_act;
    logic [NPAR_VSCR-1:0][7:0]  vsa;
    logic [7:0]                 cx;
    logic [7:0]                 cy;
    logic                       soft_rst;
    logic [31:0]                frm_cnt;
    logic                       tick;
    logic [31:0]                len;
    logic [PIXW-1:0]            pix;
  } dev_regs_t;

  dev_regs_t       r;
  dev_regs_t       r_nxt;
  logic [PIXW-1:0] mem [COLS*ROWS];
  logic            mem_we;
  logic [AW-1:0]   mem_wa;
  logic [PIXW-1:0] mem_wd;
  logic [PIXW-1:0] src_pix;

  // number of parameter bytes a command code expects
  function automatic logic [2:0] par_cnt(input logic [7:0] op);
    unique case (op)
      CMD_COPY:      par_cnt = NPAR_COPY;
      CMD_CLEAR:     par_cnt = NPAR_CLEAR;
      CMD_FILL_OPT:  par_cnt = NPAR_FILL;
      CMD_SCR_SETUP: par_cnt = NPAR_SCR;
      CMD_VSCR_AREA: par_cnt = NPAR_VSCR;
      default:       par_cnt = 3'h0;
    endcase
  endfunction : par_cnt

  // coordinates outside the panel give no valid address
  function automatic logic in_range(input logic [7:0] c, input logic [7:0] rw);
    in_range = (32'(c) < COLS) && (32'(rw) < ROWS);
  endfunction : in_range

  function automatic logic [AW-1:0] addr_of(input logic [7:0] c,
                                            input logic [7:0] rw);
    addr_of = AW'(32'(rw) * COLS + 32'(c));
  endfunction : addr_of

  // each 6-bit channel becomes 63 minus itself
  function automatic logic [PIXW-1:0] invert_gray(input logic [PIXW-1:0] p);
    invert_gray = ~p;
  endfunction : invert_gray

  logic [7:0] dst_c;
  logic [7:0] dst_r;
  logic       last_col;
  logic       last_row;
  logic [2:0] idx_inc;

  // destination walks in step with the source corner offset
  assign dst_c    = r.par[4] + (r.cx - r.par[0]);
  assign dst_r    = r.par[5] + (r.cy - r.par[1]);
  assign last_col = (r.cx >= r.par[2]);
  assign last_row = (r.cy >= r.par[3]);
  assign idx_inc  = r.idx + 3'h1;
  assign src_pix  = in_range(r.cx, r.cy) ? mem[addr_of(r.cx, r.cy)] : '0;

  // next state of the whole controller
  always_comb begin
    r_nxt          = r;
    r_nxt.soft_rst = 1'b0;
    r_nxt.tick     = 1'b0;
    mem_we         = 1'b0;
    mem_wa         = '0;
    mem_wd         = '0;
    r_nxt.len = 32'(div_ratio) * 32'(FRAME_ROWS)
                * (32'(ph1_clks) + 32'(ph2_clks) + 32'(ROW_FIXED));
    // core clock stands in for the oscillator in the frame counter
    if (r.frm_cnt + 32'h1 >= r.len) begin
      r_nxt.frm_cnt = '0;
      r_nxt.tick    = 1'b1;
    end else begin
      r_nxt.frm_cnt = r.frm_cnt + 32'h1;
    end
    r_nxt.pix = in_range(pix_col, pix_row) ? mem[addr_of(pix_col, pix_row)]
                                           : '0;
    if (lnk.stb && !lnk.dc && lnk.data == CMD_SOFT_RST) begin
      r_nxt.st       = S_IDLE;
      r_nxt.idx      = '0;
      r_nxt.fill     = FILL_RST;
      r_nxt.rev      = REV_RST;
      r_nxt.scr_act  = 1'b0;
      r_nxt.soft_rst = 1'b1;
    end else begin
      unique case (r.st)
        S_IDLE, S_PARAM: begin
          if (lnk.stb && !lnk.dc) begin
            // a new code drops any half-sent parameter list
            r_nxt.op  = lnk.data;
            r_nxt.idx = '0;
            r_nxt.st  = (par_cnt(lnk.data) != 3'h0) ? S_PARAM : S_IDLE;
            if (lnk.data == CMD_SCR_ON) begin
              r_nxt.scr_act = 1'b1;
            end
            if (lnk.data == CMD_SCR_OFF) begin
              r_nxt.scr_act = 1'b0;
            end
          end else if (lnk.stb && r.st == S_PARAM) begin
            r_nxt.par[r.idx] = lnk.data;
            r_nxt.idx        = idx_inc;
            if (idx_inc == par_cnt(r.op)) begin
              r_nxt.st = S_IDLE;
              r_nxt.cx = r_nxt.par[0];
              r_nxt.cy = r_nxt.par[1];
              unique case (r.op)
                CMD_COPY:      r_nxt.st = S_COPY;
                CMD_CLEAR:     r_nxt.st = S_CLEAR;
                CMD_FILL_OPT: begin
                  r_nxt.fill = lnk.data[FILL_BIT];
                  r_nxt.rev  = lnk.data[REV_BIT];
                end
                CMD_SCR_SETUP: r_nxt.scr = r_nxt.par[NPAR_SCR-1:0];
                CMD_VSCR_AREA: r_nxt.vsa = r_nxt.par[NPAR_VSCR-1:0];
                default:       r_nxt.st = S_IDLE;
              endcase
            end
          end
        end
        S_COPY, S_CLEAR: begin
          if (r.st == S_COPY) begin
            mem_we = in_range(dst_c, dst_r) && in_range(r.cx, r.cy);
            mem_wa = addr_of(dst_c, dst_r);
            mem_wd = r.rev ? invert_gray(src_pix) : src_pix;
          end else begin
            mem_we = in_range(r.cx, r.cy);
            mem_wa = addr_of(r.cx, r.cy);
            mem_wd = '0;
          end
          // row-major walk over the rectangle
          if (!last_col) begin
            r_nxt.cx = r.cx + 8'h1;
          end else if (!last_row) begin
            r_nxt.cx = r.par[0];
            r_nxt.cy = r.cy + 8'h1;
          end else begin
            r_nxt.st = S_IDLE;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // display memory has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign lnk.busy      = (r.st == S_COPY) || (r.st == S_CLEAR);
  assign pix_data      = r.pix;
  assign frame_len     = r.len;
  assign frame_tick    = r.tick;
  assign fill_en       = r.fill;
  assign rev_copy      = r.rev;
  assign scroll_active = r.scr_act;
  assign scroll_cfg    = r.scr;
  assign vscroll_area  = r.vsa;
  assign soft_rst      = r.soft_rst;
endmodule : gfx_dev
`default_nettype wire

// file: logic/gfx_pkg.sv
// shared constants and types for the graphic command link
package gfx_pkg;
  // command codes
  localparam logic [7:0] CMD_COPY      = 8'h23;
  localparam logic [7:0] CMD_CLEAR     = 8'h24;
  localparam logic [7:0] CMD_FILL_OPT  = 8'h26;
  localparam logic [7:0] CMD_SCR_SETUP = 8'h27;
  localparam logic [7:0] CMD_SCR_OFF   = 8'h2e;
  localparam logic [7:0] CMD_SCR_ON    = 8'h2f;
  localparam logic [7:0] CMD_VSCR_AREA = 8'ha3;
  localparam logic [7:0] CMD_SOFT_RST  = 8'he2;
  // parameter byte counts
  localparam logic [2:0] NPAR_COPY     = 3'h6;
  localparam logic [2:0] NPAR_CLEAR    = 3'h4;
  localparam logic [2:0] NPAR_FILL     = 3'h1;
  localparam logic [2:0] NPAR_SCR      = 3'h5;
  localparam logic [2:0] NPAR_VSCR     = 3'h3;
  // fill option fields and reset values
  localparam int         FILL_BIT      = 0;
  localparam int         REV_BIT       = 4;
  localparam logic       FILL_RST      = 1'b0;
  localparam logic       REV_RST       = 1'b0;
  // frame timing: rows per frame and fixed part of row length
  localparam logic [7:0] FRAME_ROWS    = 8'h84;
  localparam logic [7:0] ROW_FIXED     = 8'h62;
  // host settle time after an operation ends
  localparam int         CLK_PERIOD_PS = 5000;
  localparam int         SETTLE_NS     = 20;
  localparam int         SETTLE_CLKS   = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
  // host register byte offsets and bit positions
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam int         CMD_DC_BIT    = 8;
  localparam int         ST_BUSY_BIT   = 0;
  localparam int         ST_SETTLE_BIT = 1;
  localparam int         ST_SEND_BIT   = 2;

  typedef enum logic [1:0] {S_IDLE, S_PARAM, S_COPY, S_CLEAR} dev_state_t;
endpackage : gfx_pkg

// file: logic/gfx_link_if.sv
// command port between host end and display controller end
`timescale 1ns/100ps
`default_nettype none
interface gfx_link_if (
  input wire logic core_clk
);
  logic       stb;   // one-cycle byte strobe
  logic       dc;    // 0 command byte, 1 parameter byte
  logic [7:0] data;
  logic       busy;  // copy or clear running

  modport dev  (input stb, input dc, input data, output busy);
  modport host (output stb, output dc, output data, input busy);
endinterface : gfx_link_if
`default_nettype wire

// file: logic/gfx_host.sv
// host end: avalon-mm registers that push bytes onto the command port
`timescale 1ns/100ps
`default_nettype none
module gfx_host
  import gfx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  gfx_link_if.host         lnk,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);
  typedef struct packed {
    logic        stb;
    logic        dc;
    logic [7:0]  data;
    logic [7:0]  settle;
    logic        busy_q;
    logic        rd_ack;
    logic [31:0] rdata;
  } host_regs_t;

  host_regs_t r;
  host_regs_t r_nxt;
  logic       cmd_hold;
  logic       cmd_take;

  // hold new bytes while busy or settling
  // busy_q covers the cycle before the settle count is loaded
  assign cmd_hold = r.stb || lnk.busy || r.busy_q || (r.settle != 8'h0);
  assign cmd_take = write && (address == REG_CMD) && !cmd_hold;

  // reads take one wait state so read data come from a flop
  always_comb begin
    r_nxt        = r;
    r_nxt.stb    = cmd_take;
    r_nxt.busy_q = lnk.busy;
    r_nxt.rd_ack = read && !r.rd_ack;
    // bytes go out in the order software writes them
    if (cmd_take) begin
      r_nxt.dc   = writedata[CMD_DC_BIT];
      r_nxt.data = writedata[7:0];
    end
    if (r.busy_q && !lnk.busy) begin
      r_nxt.settle = 8'(SETTLE_CLKS);
    end else if (r.settle != 8'h0) begin
      r_nxt.settle = r.settle - 8'h1;
    end
    r_nxt.rdata = '0;
    if (address == REG_CMD) begin
      r_nxt.rdata = {23'h0, r.dc, r.data};
    end else if (address == REG_STATUS) begin
      r_nxt.rdata[ST_BUSY_BIT]   = lnk.busy;
      r_nxt.rdata[ST_SETTLE_BIT] = (r.settle != 8'h0) || r.busy_q;
      r_nxt.rdata[ST_SEND_BIT]   = r.stb;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign waitrequest = (read && !r.rd_ack)
                       || (write && (address == REG_CMD) && cmd_hold);
  assign readdata    = r.rdata;
  assign lnk.stb     = r.stb;
  assign lnk.dc      = r.dc;
  assign lnk.data    = r.data;
endmodule : gfx_host
`default_nettype wire

// file: testbench/gfx_link_assertions.sv
// link checker: byte pacing, walk length and settle gap
`timescale 1ns/100ps
`default_nettype none
module gfx_link_assertions
  import gfx_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       stb,
  input wire logic       dc,
  input wire logic [7:0] data,
  input wire logic       busy
);
  logic [7:0]  cmd_r;
  logic [2:0]  cnt_r;
  logic [7:0]  par_r [4];
  logic [16:0] len_r;
  logic [8:0]  wc;
  logic [8:0]  wr;
  logic [16:0] exp_len;
  logic        last_gfx;
  // last coordinate byte of copy or clear starts a walk
  assign last_gfx = stb && dc && ((cmd_r == CMD_COPY && cnt_r == 3'h5) ||
                                  (cmd_r == CMD_CLEAR && cnt_r == 3'h3));
  // rectangle size; a swapped pair walks a single column or row
  assign wc = (par_r[0] <= par_r[2]) ?
              {1'b0, par_r[2] - par_r[0]} + 9'h1 : 9'h1;
  assign wr = (par_r[1] <= par_r[3]) ?
              {1'b0, par_r[3] - par_r[1]} + 9'h1 : 9'h1;
  assign exp_len = {8'h0, wc} * {8'h0, wr};
  // follow command and count busy cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      cnt_r <= 3'h0;
      len_r <= 17'h0;
    end else begin
      len_r <= busy ? len_r + 17'h1 : 17'h0;
      if (stb && !dc) begin
        cmd_r <= data;
        cnt_r <= 3'h0;
      end else if (stb && dc) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end
  // corners kept apart: no reset needed, only read during a walk
  always_ff @(posedge core_clk) begin
    if (stb && dc && cnt_r < 3'h4) begin
      par_r[cnt_r[1:0]] <= data;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_stb_pulse: assert property (stb |=> !stb)
    else $error("strobe held too long");
  a_walk_start: assert property (last_gfx |=> busy)
    else $error("no busy after last byte");
  a_walk_cause: assert property ($rose(busy) |-> $past(last_gfx))
    else $error("busy without a request");
  a_walk_length: assert property ($fell(busy) |-> len_r == exp_len)
    else $error("walk length wrong");
  a_walk_bound: assert property (busy |-> len_r < exp_len)
    else $error("walk overran");
  a_walk_early: assert property (
    busy && len_r + 17'h1 < exp_len |=> busy)
    else $error("walk ended early");
  a_busy_quiet: assert property (busy |-> !stb)
    else $error("byte sent while busy");
  a_settle_gap: assert property ($fell(busy) |-> !stb [*4])
    else $error("byte sent while settling");
  c_copy: cover property (last_gfx && cmd_r == CMD_COPY);
  c_clear: cover property (last_gfx && cmd_r == CMD_CLEAR);
  c_settle: cover property ($fell(busy));
endmodule : gfx_link_assertions
`default_nettype wire

// file: testbench/testbench.sv
// top bench: host registers drive the controller over the link
`timescale 1ns/100ps
`default_nettype none
module testbench
  import gfx_pkg::*;
;
  logic        core_clk;
  logic        rst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  pix_col;
  logic [7:0]  pix_row;
  logic [17:0] pix_data;
  logic [31:0] frame_len;
  logic        frame_tick;
  logic [4:0]  div_ratio;
  logic [5:0]  ph1_clks;
  logic [3:0]  ph2_clks;
  logic        fill_en;
  logic        rev_copy;
  logic        scroll_active;
  logic [39:0] scroll_cfg;
  logic [23:0] vscroll_area;
  logic        soft_rst;
  logic [31:0] rdat;
  int          error_cnt;
  int          n_tests;
  int          srst_cnt = 0;
  gfx_link_if lnk_if (.core_clk(core_clk));
  gfx_host gfx_host_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk_if),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  // frame timing from the bench: div 2, phases 3 and 2 at start
  gfx_dev gfx_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk_if),
    .pix_col(pix_col), .pix_row(pix_row), .pix_data(pix_data),
    .div_ratio(div_ratio), .ph1_clks(ph1_clks), .ph2_clks(ph2_clks),
    .frame_len(frame_len), .frame_tick(frame_tick), .fill_en(fill_en),
    .rev_copy(rev_copy), .scroll_active(scroll_active),
    .scroll_cfg(scroll_cfg), .vscroll_area(vscroll_area),
    .soft_rst(soft_rst));
  gfx_link_assertions gfx_link_assertions_inst (.core_clk(core_clk),
    .rst_n(rst_n), .stb(lnk_if.stb), .dc(lnk_if.dc), .data(lnk_if.data),
    .busy(lnk_if.busy));
  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // count soft reset pulses
  always @(posedge core_clk) begin
    if (soft_rst === 1'b1) srst_cnt <= srst_cnt + 1;
  end
  task automatic chk(input string nm, input logic [39:0] s,
                     input logic [39:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // one bus cycle; request held until waitrequest is low at an edge
  task automatic av(input logic [3:0] a, input logic rd,
                    input logic [31:0] wd);
    int k;
    logic ok;
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= wd;
    ok = 1'b0;
    for (k = 0; k < 200 && !ok; k++) begin
      @(posedge core_clk);
      ok = (waitrequest === 1'b0);
    end
    // read data taken at the accepting edge, before the flops move
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (!ok) begin
      error_cnt++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask : av
  task automatic idle();
    int k;
    repeat (3) @(posedge core_clk);
    for (k = 0; k < 300; k++) begin
      av(REG_STATUS, 1'b1, 32'h0);
      if (rdat[2:0] == 3'h0) break;
    end
    chk("status", 40'(rdat[2:0]), 40'h0);
  endtask : idle
  // first byte is the code, the rest parameters
  task automatic run(input logic [7:0] q[$]);
    foreach (q[i]) av(REG_CMD, 1'b0, {23'h0, i != 0, q[i]});
    idle();
  endtask : run
  task automatic pix(input logic [7:0] c, input logic [7:0] r,
                     input logic [17:0] e);
    pix_col <= c;
    pix_row <= r;
    repeat (2) @(posedge core_clk);
    chk("pix_data", 40'(pix_data), 40'(e));
  endtask : pix
  task automatic t_reset();
    chk("fill_en", 40'(fill_en), 40'h0);
    chk("rev_copy", 40'(rev_copy), 40'h0);
    chk("frame_len", 40'(frame_len), 40'(2 * 132 * (3 + 2 + 98)));
    av(4'h8, 1'b1, 32'h0);
    chk("unmapped", 40'(rdat), 40'h0);
    $display("reset done");
  endtask : t_reset
  task automatic t_move();
    run('{CMD_FILL_OPT, 8'h11});
    chk("fill_en", 40'(fill_en), 40'h1);
    chk("rev_copy", 40'(rev_copy), 40'h1);
    run('{CMD_CLEAR, 8'h00, 8'h00, 8'h01, 8'h00});
    pix(8'h01, 8'h00, 18'h0);
    run('{CMD_COPY, 8'h00, 8'h00, 8'h01, 8'h00, 8'h05, 8'h05});
    pix(8'h05, 8'h05, 18'h3ffff);
    pix(8'h06, 8'h05, 18'h3ffff);
    run('{CMD_FILL_OPT, 8'h00});
    chk("rev_copy", 40'(rev_copy), 40'h0);
    run('{CMD_COPY, 8'h05, 8'h05, 8'h06, 8'h05, 8'h00, 8'h01});
    pix(8'h01, 8'h01, 18'h3ffff);
    run('{CMD_CLEAR, 8'h05, 8'h05, 8'h06, 8'h05});
    pix(8'h06, 8'h05, 18'h0);
    $display("move done");
  endtask : t_move
  task automatic t_scroll();
    run('{CMD_SCR_SETUP, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    run('{CMD_SCR_ON});
    chk("scroll_cfg", 40'(scroll_cfg), 40'h0504030201);
    chk("scroll_on", 40'(scroll_active), 40'h1);
    run('{CMD_SCR_OFF});
    chk("scroll_on", 40'(scroll_active), 40'h0);
    run('{CMD_VSCR_AREA, 8'h11, 8'h22});
    chk("vscroll", 40'(vscroll_area), 40'h0);
    av(REG_CMD, 1'b0, 32'h133);
    idle();
    chk("vscroll", 40'(vscroll_area), 40'h332211);
    $display("scroll done");
  endtask : t_scroll
  task automatic t_srst();
    run('{CMD_FILL_OPT, 8'h11});
    run('{CMD_SCR_ON});
    run('{CMD_SOFT_RST});
    chk("fill_en", 40'(fill_en), 40'h0);
    chk("scroll_on", 40'(scroll_active), 40'h0);
    chk("soft_rst", 40'(srst_cnt), 40'h1);
    $display("soft reset done");
  endtask : t_srst
  // shortest frame: div 1, both phases 0, so K is the fixed part
  task automatic t_frame();
    int k;
    div_ratio <= 5'h01;
    ph1_clks <= 6'h00;
    ph2_clks <= 4'h0;
    repeat (2) @(posedge core_clk);
    chk("frame_len", 40'(frame_len), 40'(132 * 98));
    k = 0;
    while (frame_tick !== 1'b1 && k < 14000) begin
      @(posedge core_clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (frame_tick !== 1'b1 && k < 14000);
    chk("frame_period", 40'(k), 40'(132 * 98));
    $display("frame done");
  endtask : t_frame
  // main sequence
  initial begin
    rst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    pix_col = 8'h00;
    pix_row = 8'h00;
    div_ratio = 5'h02;
    ph1_clks = 6'h03;
    ph2_clks = 4'h2;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // second edge lets frame_len load before it is read
    repeat (2) @(posedge core_clk);
    t_reset();
    t_move();
    t_scroll();
    t_srst();
    t_frame();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
